//--- mcsc_pkg.sv
// constants and carrier types for the motor control source configuration bank
package mcsc_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	localparam logic [7:0] OFS_FAIL_REACT = 8'h71;
	localparam logic [7:0] OFS_PROT_EN    = 8'h72;
	localparam logic [7:0] OFS_SRC_SEL    = 8'h73;
	localparam logic [7:0] OFS_BUS_CFG    = 8'h74;
	localparam logic [7:0] OFS_HW_CFG     = 8'h75;

	localparam logic [15:0] RST_FAIL_REACT = 16'h000A;
	localparam logic [15:0] RST_PROT_EN    = 16'hFFBF;
	localparam logic [15:0] RST_SRC_SEL    = 16'h0022;
	localparam logic [15:0] RST_BUS_CFG    = 16'h005C;
	localparam logic [15:0] RST_HW_CFG     = 16'h2804;

	localparam logic [15:0] MAX_FAIL_REACT = 16'h007F;
	localparam logic [15:0] MAX_PROT_EN    = 16'hFFFF;
	localparam logic [15:0] MAX_SRC_SEL    = 16'h007F;
	localparam logic [15:0] MAX_BUS_CFG    = 16'h007F;
	localparam logic [15:0] MAX_HW_CFG     = 16'h0005;

	localparam int BIT_C1_LOCAL   = 0;
	localparam int FLD_MB_LO      = 4;
	localparam int FLD_SRC_LO     = 0;
	localparam int FLD_SEL_LO     = 4;
	localparam int BIT_C1_EN      = 0;
	localparam int BIT_C1_TWO     = 1;
	localparam int BIT_C1_EDGE    = 2;
	localparam int BIT_C1_INV_OFF = 3;
	localparam int BIT_C2_EN      = 4;
	localparam int BIT_MB_EN      = 6;
	localparam int BIT_HW_EN      = 0;
	localparam int BIT_HW_TWO     = 1;
	localparam int BIT_HW_EDGE    = 2;

	localparam logic [2:0] CODE_NONE   = 3'h0;
	localparam logic [2:0] CODE_C1     = 3'h1;
	localparam logic [2:0] CODE_MB     = 3'h2;
	localparam logic [2:0] CODE_HW     = 3'h3;
	localparam logic [2:0] CODE_FLOCAL = 3'h4;
	localparam logic [2:0] CODE_FREM   = 3'h5;
	localparam logic [2:0] CODE_OFF    = 3'h3;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} mcsc_req_t;

	typedef struct packed {
		logic       on;
		logic       off;
		logic       reset;
	} mcsc_cmd_t;

	typedef struct packed {
		logic       c1_two_bit;
		logic       c1_edge;
		logic       c1_inv_off;
		logic       hw_en;
		logic       hw_two_bit;
		logic       hw_edge;
	} mcsc_mode_t;
endpackage : mcsc_pkg

//--- mcsc_config_bank.sv
// holding-register bank for command source, protection enables and failure reaction
`timescale 1ns/1ps
//Contract
// R1: fail-react bit 0 forces switch local on class 1 bus failure; here a Modbus failure with remote reaction in the same cycle overrides it.
// R2: fail-react bits 4-6 on Modbus failure: none, local, remote, off.
// R3: protection enable register has one bit per protection, fixed order.
// R4: disabled protection's fault or alarm is ignored; enabled one is activated.
// R5: gating applies identically to all sixteen protection bits.
// R6: source bits 0-2 pick remote command source: class1, Modbus, hardwire.
// R7: source bits 4-6 pick local/remote selector driver incl. fixed local/remote.
// R8: bus command config holds class1/class2/Modbus enables and class1 options.
// R9: ON, OFF, reset commands accepted only from enabled protocols.
// R10: master sets class1 width, edge, polarity bits when enabling class1.
// R11: hardwire config holds enable, width and level/edge bits.
// R12: configurer sets hardwire width and edge bits when enabling hardwire; code refuses writes above 0x0005, so 0x0007 is rejected.
// R13: source, bus command and hardwire registers are written in one sequence.
// R14: writes above a register's maximum are ignored, contents kept.
module mcsc_config_bank (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              ce,
	input  wire mcsc_pkg::mcsc_req_t req,
	output logic [15:0]            rdata,
	output logic                   rvalid,
	output logic                   wr_err,
	input  wire logic [15:0]       prot_fault_raw,
	input  wire logic [15:0]       prot_alarm_raw,
	output logic [15:0]            prot_fault,
	output logic [15:0]            prot_alarm,
	input  wire logic              c1_fail,
	input  wire logic              mb_fail,
	input  wire logic              hw_remote_sel,
	input  wire mcsc_pkg::mcsc_cmd_t c1_cmd,
	input  wire mcsc_pkg::mcsc_cmd_t c2_cmd,
	input  wire mcsc_pkg::mcsc_cmd_t mb_cmd,
	input  wire mcsc_pkg::mcsc_cmd_t hw_cmd,
	input  wire logic              c1_remote_req,
	input  wire logic              mb_remote_req,
	output mcsc_pkg::mcsc_cmd_t    motor_cmd,
	output logic                   remote_mode,
	output logic                   force_off,
	output mcsc_pkg::mcsc_mode_t   mode
);
	import mcsc_pkg::*;

	logic [15:0] fail_q;
	logic [15:0] fail_d;
	logic [15:0] prot_q;
	logic [15:0] prot_d;
	logic [15:0] src_q;
	logic [15:0] src_d;
	logic [15:0] bus_q;
	logic [15:0] bus_d;
	logic [15:0] hw_q;
	logic [15:0] hw_d;
	logic [15:0] rdata_d;
	logic        rvalid_d;
	logic        wr_err_d;
	logic [15:0] pf_d;
	logic [15:0] pa_d;
	mcsc_cmd_t   cmd_d;
	logic        remote_q;
	logic        remote_d;
	logic        off_d;
	logic        hw_s1_q;
	logic        hw_s2_q;
	logic        c1f_s1_q;
	logic        c1f_s2_q;
	logic        mbf_s1_q;
	logic        mbf_s2_q;
	mcsc_cmd_t   hwc_s1_q;
	mcsc_cmd_t   hwc_s2_q;
	mcsc_mode_t  mode_d;

	// true when the write value lies within the register's range
	function automatic logic in_range(input logic [15:0] v, input logic [15:0] mx);
		in_range = (v <= mx);
	endfunction : in_range

	// gate a command by its protocol enable
	function automatic mcsc_cmd_t gate_cmd(input mcsc_cmd_t c, input logic en);
		gate_cmd = en ? c : '0;
	endfunction : gate_cmd

	always_comb begin
		fail_d   = fail_q;
		prot_d   = prot_q;
		src_d    = src_q;
		bus_d    = bus_q;
		hw_d     = hw_q;
		wr_err_d = 1'b0;
		rvalid_d = 1'b0;
		rdata_d  = rdata;
		if (req.wr) begin
			if (req.addr == OFS_FAIL_REACT) begin
				if (in_range(req.wdata, MAX_FAIL_REACT)) fail_d = req.wdata; // R14
				else wr_err_d = 1'b1;
			end else if (req.addr == OFS_PROT_EN) begin
				if (in_range(req.wdata, MAX_PROT_EN)) prot_d = req.wdata; // R3
				else wr_err_d = 1'b1;
			end else if (req.addr == OFS_SRC_SEL) begin
				if (in_range(req.wdata, MAX_SRC_SEL)) src_d = req.wdata; // R14
				else wr_err_d = 1'b1;
			end else if (req.addr == OFS_BUS_CFG) begin
				if (in_range(req.wdata, MAX_BUS_CFG)) bus_d = req.wdata; // R8
				else wr_err_d = 1'b1;
			end else if (req.addr == OFS_HW_CFG) begin
				if (in_range(req.wdata, MAX_HW_CFG)) hw_d = req.wdata; // R11
				else wr_err_d = 1'b1;
			end else begin
				wr_err_d = 1'b1;
			end
		end
		if (req.rd) begin
			rvalid_d = 1'b1;
			// unmapped reads answer zero
			if (req.addr == OFS_FAIL_REACT) rdata_d = fail_q;
			else if (req.addr == OFS_PROT_EN) rdata_d = prot_q;
			else if (req.addr == OFS_SRC_SEL) rdata_d = src_q;
			else if (req.addr == OFS_BUS_CFG) rdata_d = bus_q;
			else if (req.addr == OFS_HW_CFG) rdata_d = hw_q;
			else rdata_d = '0;
		end
	end

	always_comb begin
		// every protection bit gated the same way
		pf_d = prot_fault_raw & prot_q; // R4 R5
		pa_d = prot_alarm_raw & prot_q; // R4 R5
		cmd_d = '0;
		case (src_q[FLD_SRC_LO +: 3]) // R6
			// class 1 commands need their own enable; class 2 has its own path
			CODE_C1: cmd_d = gate_cmd(c1_cmd, bus_q[BIT_C1_EN]); // R9
			CODE_MB: cmd_d = gate_cmd(mb_cmd, bus_q[BIT_MB_EN]); // R9
			CODE_HW: cmd_d = gate_cmd(hwc_s2_q, hw_q[BIT_HW_EN]); // R9
			default: cmd_d = '0;
		endcase
		// class 2 acyclic commands ride alongside whichever source is active
		cmd_d = cmd_d | gate_cmd(c2_cmd, bus_q[BIT_C2_EN]); // R9
		remote_d = remote_q;
		case (src_q[FLD_SEL_LO +: 3]) // R7
			CODE_C1:     remote_d = c1_remote_req;
			CODE_MB:     remote_d = mb_remote_req;
			CODE_HW:     remote_d = hw_s2_q;
			CODE_FLOCAL: remote_d = 1'b0;
			CODE_FREM:   remote_d = 1'b1;
			// unused selector codes hold the last state
			default:     remote_d = remote_q;
		endcase
		off_d = 1'b0;
		if (c1f_s2_q && fail_q[BIT_C1_LOCAL]) remote_d = 1'b0; // R1
		if (mbf_s2_q) begin
			case (fail_q[FLD_MB_LO +: 3]) // R2
				CODE_C1: remote_d = 1'b0;
				CODE_MB: remote_d = 1'b1;
				CODE_OFF: off_d = 1'b1;
				default: ;
			endcase
		end
		// switch-off reaction overrides every source command
		if (off_d) cmd_d = '{on: 1'b0, off: 1'b1, reset: 1'b0};
		mode_d.c1_two_bit = bus_q[BIT_C1_TWO];
		mode_d.c1_edge    = bus_q[BIT_C1_EDGE];
		mode_d.c1_inv_off = bus_q[BIT_C1_INV_OFF];
		mode_d.hw_en      = hw_q[BIT_HW_EN];
		mode_d.hw_two_bit = hw_q[BIT_HW_TWO];
		mode_d.hw_edge    = hw_q[BIT_HW_EDGE];
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fail_q     <= RST_FAIL_REACT;
			prot_q     <= RST_PROT_EN;
			src_q      <= RST_SRC_SEL;
			bus_q      <= RST_BUS_CFG;
			// power-up hardwire default lies above the write range; only writes are checked
			hw_q       <= RST_HW_CFG;
			rdata      <= '0;
			rvalid     <= 1'b0;
			wr_err     <= 1'b0;
			prot_fault <= '0;
			prot_alarm <= '0;
			motor_cmd  <= '0;
			remote_q   <= 1'b0;
			remote_mode <= 1'b0;
			force_off  <= 1'b0;
			mode       <= '0;
			hw_s1_q    <= 1'b0;
			hw_s2_q    <= 1'b0;
			c1f_s1_q   <= 1'b0;
			c1f_s2_q   <= 1'b0;
			mbf_s1_q   <= 1'b0;
			mbf_s2_q   <= 1'b0;
			hwc_s1_q   <= '0;
			hwc_s2_q   <= '0;
		end else if (ce) begin
			fail_q     <= fail_d;
			prot_q     <= prot_d;
			src_q      <= src_d;
			bus_q      <= bus_d;
			hw_q       <= hw_d;
			rdata      <= rdata_d;
			rvalid     <= rvalid_d;
			wr_err     <= wr_err_d;
			prot_fault <= pf_d;
			prot_alarm <= pa_d;
			motor_cmd  <= cmd_d;
			remote_q   <= remote_d;
			remote_mode <= remote_d;
			force_off  <= off_d;
			mode       <= mode_d;
			// pin-level inputs pass two flops before use
			hw_s1_q    <= hw_remote_sel;
			hw_s2_q    <= hw_s1_q;
			c1f_s1_q   <= c1_fail;
			c1f_s2_q   <= c1f_s1_q;
			mbf_s1_q   <= mb_fail;
			mbf_s2_q   <= mbf_s1_q;
			hwc_s1_q   <= hw_cmd;
			hwc_s2_q   <= hwc_s1_q;
		end
	end
endmodule : mcsc_config_bank

//--- mcsc_chk.sv
// port checker for the source configuration bank
`timescale 1ns/1ps
module mcsc_chk (
	input wire logic                clk,
	input wire logic                rst_n,
	input wire logic                ce,
	input wire mcsc_pkg::mcsc_req_t req,
	input wire logic [15:0]         rdata,
	input wire logic                rvalid,
	input wire logic                wr_err,
	input wire logic [15:0]         prot_fault_raw,
	input wire logic [15:0]         prot_alarm_raw,
	input wire logic [15:0]         prot_fault,
	input wire logic [15:0]         prot_alarm,
	input wire logic                force_off
);
	import mcsc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	read_answer_a: assert property (ce && req.rd |=> rvalid) else $error("read unanswered");
	no_stray_a: assert property (rvalid && $past(ce) |-> $past(req.rd))
		else $error("stray rvalid");
	fault_mask_a: assert property (ce |=> (prot_fault & ~$past(prot_fault_raw)) == 16'h0000)
		else $error("fault without raw event");
	alarm_mask_a: assert property (ce |=> (prot_alarm & ~$past(prot_alarm_raw)) == 16'h0000)
		else $error("alarm without raw event");
	unmapped_err_a: assert property (ce && req.wr
		&& (req.addr < OFS_FAIL_REACT || req.addr > OFS_HW_CFG) |=> wr_err)
		else $error("unmapped write accepted");
	hw_range_a: assert property (ce && req.wr && req.addr == OFS_HW_CFG
		&& req.wdata > MAX_HW_CFG |=> wr_err) else $error("hw config over range accepted");
	react_ok_a: assert property (ce && req.wr && req.addr == OFS_FAIL_REACT
		&& req.wdata <= MAX_FAIL_REACT |=> !wr_err) else $error("legal write refused");
	mask_full_a: assert property (ce && req.wr && req.addr == OFS_PROT_EN |=> !wr_err)
		else $error("mask write refused");
	unmapped_rd_a: assert property (ce && req.rd && req.addr == 8'h70 |=> rdata == 16'h0000)
		else $error("unmapped read not zero");
	cover property (ce && req.wr ##1 wr_err);
	cover property (rvalid);
	cover property (force_off);
endmodule : mcsc_chk

bind mcsc_config_bank mcsc_chk u_chk (.clk(clk), .rst_n(rst_n), .ce(ce), .req(req),
	.rdata(rdata), .rvalid(rvalid), .wr_err(wr_err), .prot_fault_raw(prot_fault_raw),
	.prot_alarm_raw(prot_alarm_raw), .prot_fault(prot_fault), .prot_alarm(prot_alarm),
	.force_off(force_off));

//--- mcsc_master.sv
// fieldbus master model issuing one-cycle register requests
`timescale 1ns/1ps
module mcsc_master (
	input wire logic          clk,
	input wire logic [15:0]   rdata,
	input wire logic          rvalid,
	input wire logic          wr_err,
	output mcsc_pkg::mcsc_req_t req
);
	import mcsc_pkg::*;
	initial req = '0;
	// answer is registered, so it is visible at the falling edge after the taking edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic v, output logic e);
		@(negedge clk);
		req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge clk);
		req = '0;
		q = rdata;
		v = rvalid;
		e = wr_err;
	endtask : xfer
	// the three source registers always go out as one sequence
	task automatic cfg(input logic [15:0] s, input logic [15:0] b, input logic [15:0] h);
		logic [15:0] q;
		logic        v;
		logic        e;
		xfer(1'b1, OFS_SRC_SEL, s, q, v, e);
		xfer(1'b1, OFS_BUS_CFG, b, q, v, e);
		xfer(1'b1, OFS_HW_CFG, h, q, v, e);
	endtask : cfg
endmodule : mcsc_master

//--- mcsc_tb.sv
// self-checking bench for the source configuration bank
`timescale 1ns/1ps
module testbench;
	import mcsc_pkg::*;
	typedef struct packed {logic [7:0] a; logic [15:0] d; logic [15:0] x; logic e;} mcsc_row_t;
	mcsc_row_t rows [11] = '{'{8'h71, 16'h007F, 16'h007F, 1'b0}, '{8'h71, 16'h0080, 16'h007F, 1'b1},
		'{8'h72, 16'h0000, 16'h0000, 1'b0}, '{8'h72, 16'hFFFF, 16'hFFFF, 1'b0},
		'{8'h73, 16'h0055, 16'h0055, 1'b0}, '{8'h73, 16'h0080, 16'h0055, 1'b1},
		'{8'h74, 16'h007F, 16'h007F, 1'b0}, '{8'h74, 16'h0100, 16'h007F, 1'b1},
		'{8'h75, 16'h0005, 16'h0005, 1'b0}, '{8'h75, 16'h0006, 16'h0005, 1'b1},
		'{8'h70, 16'h0001, 16'h0000, 1'b1}};
	logic [15:0] dflt [5] = '{RST_FAIL_REACT, RST_PROT_EN, RST_SRC_SEL, RST_BUS_CFG, RST_HW_CFG};
	logic        clk = 1'b0, rst_n = 1'b0, c1_fail = 1'b0, mb_fail = 1'b0, rvalid, wr_err, rm, fo;
	logic        mb_rem = 1'b0, c1_rem = 1'b0, hw_rem = 1'b0, v, e;
	logic [15:0] fraw = '0, araw = '0, pf, pa, rdata, q;
	mcsc_req_t   req;
	mcsc_cmd_t   ccmd = '0, c2c = '0, mbc = '0, hwc = '0, mc;
	mcsc_mode_t  md;
	int          bad_count = 0, num_checks = 0;
	always #20 clk = ~clk;
	mcsc_master u_mst (.clk(clk), .rdata(rdata), .rvalid(rvalid), .wr_err(wr_err), .req(req));
	mcsc_config_bank u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .req(req), .rdata(rdata),
		.rvalid(rvalid), .wr_err(wr_err), .prot_fault_raw(fraw), .prot_alarm_raw(araw),
		.prot_fault(pf), .prot_alarm(pa), .c1_fail(c1_fail), .mb_fail(mb_fail),
		.hw_remote_sel(hw_rem), .c1_cmd(ccmd), .c2_cmd(c2c), .mb_cmd(mbc), .hw_cmd(hwc),
		.c1_remote_req(c1_rem), .mb_remote_req(mb_rem), .motor_cmd(mc), .remote_mode(rm),
		.force_off(fo), .mode(md));
	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic conclude;
		$display("checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : conclude
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		conclude();
	end
	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		foreach (rows[i]) begin
			u_mst.xfer(1'b1, rows[i].a, rows[i].d, q, v, e);
			chk(e === rows[i].e, "write status");
			u_mst.xfer(1'b0, rows[i].a, 16'h0000, q, v, e);
			chk(v === 1'b1 && q === rows[i].x, "readback");
		end
		$display("test done: table");
		u_mst.xfer(1'b1, OFS_PROT_EN, 16'h8001, q, v, e);
		fraw = 16'hFFFF;
		araw = 16'hFFFF;
		repeat (2) @(negedge clk);
		chk(pf === 16'h8001 && pa === 16'h8001, "protection gating");
		u_mst.cfg(16'h0052, 16'h0000, 16'h0000);
		ccmd = 3'b100;
		mbc = 3'b100;
		c2c = 3'b010;
		hwc = 3'b001;
		mb_rem = 1'b1;
		repeat (3) @(negedge clk);
		chk(mc === 3'b000, "disabled protocol command taken");
		u_mst.cfg(16'h0052, 16'h004E, 16'h0005);
		repeat (2) @(negedge clk);
		chk(mc === 3'b100 && rm === 1'b1, "enabled command or selector");
		chk(md === 6'b111101, "mode copies");
		u_mst.xfer(1'b1, OFS_FAIL_REACT, 16'h0031, q, v, e);
		c1_fail = 1'b1;
		mb_fail = 1'b1;
		repeat (5) @(negedge clk);
		chk(fo === 1'b1 && rm === 1'b0 && mc === 3'b010, "failure reaction");
		u_mst.xfer(1'b1, OFS_FAIL_REACT, 16'h0010, q, v, e);
		repeat (2) @(negedge clk);
		chk(rm === 1'b0 && fo === 1'b0 && mc === 3'b100, "modbus failure to local");
		u_mst.xfer(1'b1, OFS_FAIL_REACT, 16'h0000, q, v, e);
		repeat (2) @(negedge clk);
		chk(rm === 1'b1 && fo === 1'b0, "no reaction keeps selector");
		u_mst.cfg(16'h0042, 16'h004E, 16'h0005);
		u_mst.xfer(1'b1, OFS_FAIL_REACT, 16'h0020, q, v, e);
		repeat (2) @(negedge clk);
		chk(rm === 1'b1, "modbus failure to remote");
		c1_fail = 1'b0;
		mb_fail = 1'b0;
		hw_rem = 1'b1;
		u_mst.cfg(16'h0033, 16'h001F, 16'h0005);
		repeat (2) @(negedge clk);
		chk(mc === 3'b011 && rm === 1'b1, "hardwire source and selector");
		u_mst.cfg(16'h0011, 16'h000F, 16'h0000);
		repeat (2) @(negedge clk);
		chk(mc === 3'b100 && rm === 1'b0, "class 1 source and selector");
		c1_rem = 1'b1;
		u_mst.cfg(16'h0011, 16'h0010, 16'h0000);
		repeat (2) @(negedge clk);
		chk(mc === 3'b010 && rm === 1'b1, "class 1 command without its enable");
		$display("test done: datapath");
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		for (int i = 0; i < 5; i++) begin
			u_mst.xfer(1'b0, 8'(8'h71 + i), 16'h0000, q, v, e);
			chk(q === dflt[i], "reset value");
		end
		$display("test done: reset");
		conclude();
	end
endmodule : testbench
